// ==== hw/i2c_pkg.sv ====
// Shared constants and state types for the two-wire register port
package i2c_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // ==========================================================
  // Bus encodings
  localparam logic [6:0] CLIENT_ADDR_DEF = 7'h3C;
  localparam logic RW_WR = 1'b0;
  localparam logic RW_RD = 1'b1;
  localparam logic ACK = 1'b0;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam int REG_DEPTH_DEF = 256;
  localparam int FIFO_DEPTH_DEF = 8;
  // Quarter phases of one host bit time
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  // ==========================================================
  // State types
  typedef enum logic [3:0] {
    C_IDLE = 4'h0, C_ADDR = 4'h1, C_ADDR_ACK = 4'h2, C_REGA = 4'h3,
    C_REGA_ACK = 4'h4, C_WDATA = 4'h5, C_WDATA_ACK = 4'h6,
    C_RDATA = 4'h7, C_RACK = 4'h8, C_IGNORE = 4'h9
  } cli_st_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_START = 3'h1, H_TX = 3'h2, H_RX = 3'h3, H_STOP = 3'h4
  } host_st_t;
  typedef enum logic [2:0] {
    SQ_AW = 3'h0, SQ_REG = 3'h1, SQ_WD = 3'h2, SQ_AR = 3'h3, SQ_RD = 3'h4
  } seq_t;
endpackage

// ==== hw/i2c_link_if.sv ====
// Open-drain two-wire link joining host end and client end
`timescale 1ns/100ps
interface i2c_link_if;
  logic scl_oe_h;
  logic scl_out_h;
  logic sda_oe_h;
  logic sda_out_h;
  logic scl_oe_c;
  logic scl_out_c;
  logic sda_oe_c;
  logic sda_out_c;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups: a line is low if any enabled driver pulls it low
  assign scl = !((scl_oe_h && !scl_out_h) || (scl_oe_c && !scl_out_c));
  assign sda = !((sda_oe_h && !sda_out_h) || (sda_oe_c && !sda_out_c));
  modport host (output scl_oe_h, scl_out_h, sda_oe_h, sda_out_h, input scl, sda);
  modport client (output scl_oe_c, scl_out_c, sda_oe_c, sda_out_c, input scl, sda);
endinterface

// ==== hw/i2c_client.sv ====
// Client end: two-wire register port with byte-wide register space
// Functional notes
// - Bits change with SCL low, sampled SCL high
// - START is SDA falling while SCL high
// - Repeated START restarts at address byte
// - STOP is SDA rising while SCL high
// - Bus busy from START until STOP
// - Any number of whole bytes accepted
// - Every byte shifted MSB first
// - Host generates every SCL pulse, ninth included
// - Never stretch SCL; byte handled in ack
// - Ack: transmitter releases, receiver pulls low
// - Nack: SDA left released whole ninth clock
// - Foreign address is not acknowledged
// - Nack unknown register or refused data (register byte always acked; data for an unknown register nacked)
// - Host nacks the last byte it reads
// - After nack host sends STOP or rSTART
// - Write: addr+W, register, data, STOP
// - Register address increments after each data byte; in reads only after bytes the host acks
// - Works at any host-chosen bus rate
// - Read: set register, rSTART, addr+R, data
`timescale 1ns/100ps
module i2c_client
  import i2c_pkg::*;
#(
  parameter logic [6:0] CLIENT_ADDR = CLIENT_ADDR_DEF,
  parameter int REG_DEPTH = REG_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  i2c_link_if.client link,
  input wire logic wr_ready,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic bus_busy
);
  // ==========================================================
  // Declarations
  logic scl_m_r;
  logic scl_s_r;
  logic scl_d_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_d_r;
  logic start_ev;
  logic stop_ev;
  logic rise;
  logic fall;
  cli_st_t st_r;
  cli_st_t st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] ptr_inc;
  logic rw_r;
  logic rw_nxt;
  logic hack_r;
  logic hack_nxt;
  logic oe_r;
  logic oe_nxt;
  logic busy_r;
  logic busy_nxt;
  logic stb_r;
  logic stb_nxt;
  logic [7:0] wa_r;
  logic [7:0] wa_nxt;
  logic [7:0] wd_r;
  logic [7:0] wd_nxt;
  logic mem_we;
  logic [7:0] rd_cur;
  logic [7:0] rd_inc;
  logic [7:0] mem [REG_DEPTH];

  // Register space decode, shared by reads and writes
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = int'(a) < REG_DEPTH;
  endfunction

  // ==========================================================
  // Pin synchronisers
  // The link is asynchronous to clk, so both lines pass two flops first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= link.scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
    end
  end

  // Line events; SDA moving with SCL high is a condition, not data
  assign start_ev = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_ev = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
  assign rise = scl_s_r && !scl_d_r;
  assign fall = !scl_s_r && scl_d_r;
  assign ptr_inc = ptr_r + 8'h01;
  // Unknown registers read back as all ones
  assign rd_cur = reg_known(ptr_r) ? mem[ptr_r] : IDLE_BYTE;
  assign rd_inc = reg_known(ptr_inc) ? mem[ptr_inc] : IDLE_BYTE;

  // ==========================================================
  // Transfer state machine, next values
  // All ack decisions land on the SCL fall that opens the ninth clock,
  // so the ack is on SDA long before the host samples it
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    hack_nxt = hack_r;
    oe_nxt = oe_r;
    busy_nxt = busy_r;
    stb_nxt = 1'b0;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    mem_we = 1'b0;
    if (stop_ev) begin
      st_nxt = C_IDLE;
      oe_nxt = 1'b0;
      busy_nxt = 1'b0;
    end else if (start_ev) begin
      st_nxt = C_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      busy_nxt = 1'b1;
    end else begin
      case (st_r)
        C_ADDR, C_REGA, C_WDATA: begin
          if (rise && cnt_r != ACK_SLOT) begin
            sh_nxt = {sh_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == ACK_SLOT) begin
            cnt_nxt = 4'h0;
            if (st_r == C_ADDR) begin
              if (sh_r[7:1] == CLIENT_ADDR) begin
                oe_nxt = 1'b1;
                rw_nxt = sh_r[0];
                st_nxt = C_ADDR_ACK;
              end else begin
                st_nxt = C_IGNORE;
              end
            end else if (st_r == C_REGA) begin
              ptr_nxt = sh_r;
              oe_nxt = 1'b1;
              st_nxt = C_REGA_ACK;
            end else if (wr_ready && reg_known(ptr_r)) begin
              mem_we = 1'b1;
              stb_nxt = 1'b1;
              wa_nxt = ptr_r;
              wd_nxt = sh_r;
              ptr_nxt = ptr_inc;
              oe_nxt = 1'b1;
              st_nxt = C_WDATA_ACK;
            end else begin
              st_nxt = C_IGNORE;
            end
          end
        end
        C_ADDR_ACK: begin
          if (fall) begin
            if (rw_r == RW_RD) begin
              tx_nxt = rd_cur;
              oe_nxt = !rd_cur[7];
              st_nxt = C_RDATA;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = C_REGA;
            end
          end
        end
        C_REGA_ACK, C_WDATA_ACK: begin
          if (fall) begin
            oe_nxt = 1'b0;
            st_nxt = C_WDATA;
          end
        end
        C_RDATA: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall) begin
            if (cnt_r == ACK_SLOT) begin
              oe_nxt = 1'b0;
              st_nxt = C_RACK;
            end else begin
              tx_nxt = {tx_r[6:0], 1'b0};
              oe_nxt = !tx_r[6];
            end
          end
        end
        C_RACK: begin
          if (rise) begin
            hack_nxt = (sda_s_r == ACK);
          end else if (fall) begin
            cnt_nxt = 4'h0;
            if (hack_r) begin
              ptr_nxt = ptr_inc;
              tx_nxt = rd_inc;
              oe_nxt = !rd_inc[7];
              st_nxt = C_RDATA;
            end else begin
              st_nxt = C_IGNORE;
            end
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Transfer state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= C_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= RW_WR;
      hack_r <= 1'b0;
      oe_r <= 1'b0;
      busy_r <= 1'b0;
      stb_r <= 1'b0;
      wa_r <= 8'h00;
      wd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      hack_r <= hack_nxt;
      oe_r <= oe_nxt;
      busy_r <= busy_nxt;
      stb_r <= stb_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
    end
  end

  // ==========================================================
  // Register space; contents are undefined until first written
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[ptr_r] <= sh_r;
    end
  end

  // ==========================================================
  // Outputs; SCL is never driven, so the host keeps the bit rate
  assign link.scl_oe_c = 1'b0;
  assign link.scl_out_c = 1'b0;
  assign link.sda_oe_c = oe_r;
  assign link.sda_out_c = 1'b0;
  assign wr_stb = stb_r;
  assign wr_addr = wa_r;
  assign wr_data = wd_r;
  assign bus_busy = busy_r;
endmodule

// ==== hw/i2c_host.sv ====
// Host end: write-data FIFO and the two-wire bus host engine
`timescale 1ns/100ps
module i2c_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;
  // ==========================================================
  // Pointer and fill count; full and empty come from the count
  assign in_ready = cnt_r != (AW + 1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    wp_nxt = push ? ((wp_r == LAST) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == LAST) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

module i2c_host
  import i2c_pkg::*;
#(
  parameter logic [6:0] CLIENT_ADDR = CLIENT_ADDR_DEF,
  parameter int QTR = QTR_CYC,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  i2c_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_len,
  output logic cmd_ready,
  input wire logic wdata_valid,
  input wire logic [7:0] wdata,
  output logic wdata_ready,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack
);
  localparam logic [15:0] QTR_LAST = 16'(QTR - 1);
  host_st_t st_r, st_nxt;
  seq_t sq_r, sq_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, len_r, len_nxt, reg_r, reg_nxt;
  logic [7:0] rdd_r, rdd_nxt;
  logic rd_r, rd_nxt, scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
  logic rdy_r, rdy_nxt, rdv_r, rdv_nxt, done_r, done_nxt, nack_r, nack_nxt;
  logic ackin_r, ackin_nxt, sda_m_r, sda_s_r;
  logic f_valid, f_pop, tick, stall;
  logic [7:0] f_data;

  // Write data waits here; an empty FIFO stalls SCL low between bytes
  i2c_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) wfifo (
    .clk(clk), .sys_rst(sys_rst), .in_valid(wdata_valid), .in_ready(wdata_ready),
    .in_data(wdata), .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data)
  );

  // ==========================================================
  // SDA synchroniser for ack and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  assign tick = tmr_r == 16'h0000;
  assign stall = st_r == H_TX && sq_r == SQ_WD && bit_r == 4'h0 && ph_r == PH_SET && !f_valid;

  // ==========================================================
  // Bus engine: four quarter phases per bit, SCL made by a divider
  always_comb begin
    st_nxt = st_r; sq_nxt = sq_r; ph_nxt = ph_r; bit_nxt = bit_r;
    tx_nxt = tx_r; rx_nxt = rx_r; len_nxt = len_r; reg_nxt = reg_r;
    rd_nxt = rd_r; scl_oe_nxt = scl_oe_r; sda_oe_nxt = sda_oe_r;
    rdy_nxt = rdy_r; rdv_nxt = 1'b0; rdd_nxt = rdd_r; done_nxt = 1'b0;
    nack_nxt = nack_r; ackin_nxt = ackin_r; f_pop = 1'b0;
    tmr_nxt = (st_r == H_IDLE || stall) ? 16'h0000 : (tick ? QTR_LAST : tmr_r - 16'h0001);
    if (st_r == H_IDLE) begin
      if (cmd_valid && rdy_r) begin
        rd_nxt = cmd_read; reg_nxt = cmd_reg; len_nxt = cmd_len;
        sq_nxt = SQ_AW; st_nxt = H_START; ph_nxt = PH_SET;
        rdy_nxt = 1'b0; nack_nxt = 1'b0;
      end
    end else if (tick && !stall) begin
      ph_nxt = ph_r + 2'h1;
      case (st_r)
        H_START: begin
          case (ph_r)
            PH_SET: sda_oe_nxt = 1'b0;
            PH_RISE: scl_oe_nxt = 1'b0;
            PH_SAMPLE: sda_oe_nxt = 1'b1; // SDA falls while SCL high
            default: begin
              scl_oe_nxt = 1'b1;
              st_nxt = H_TX;
              bit_nxt = 4'h0;
              tx_nxt = {CLIENT_ADDR, (sq_r == SQ_AR) ? RW_RD : RW_WR};
            end
          endcase
        end
        H_TX, H_RX: begin
          case (ph_r)
            PH_SET: begin
              if (st_r == H_RX) begin
                sda_oe_nxt = (bit_r == ACK_SLOT) && (len_r != 8'h01); // Nack last byte
              end else if (bit_r == ACK_SLOT) begin
                sda_oe_nxt = 1'b0;
              end else if (sq_r == SQ_WD && bit_r == 4'h0) begin
                tx_nxt = f_data;
                f_pop = 1'b1;
                sda_oe_nxt = !f_data[7];
              end else begin
                sda_oe_nxt = !tx_r[7];
              end
            end
            PH_RISE: scl_oe_nxt = 1'b0;
            PH_SAMPLE: begin
              if (bit_r == ACK_SLOT) ackin_nxt = (sda_s_r == ACK);
              else rx_nxt = {rx_r[6:0], sda_s_r};
            end
            default: begin
              scl_oe_nxt = 1'b1;
              if (bit_r != ACK_SLOT) begin
                bit_nxt = bit_r + 4'h1;
                tx_nxt = {tx_r[6:0], 1'b0};
              end else begin
                bit_nxt = 4'h0;
                if (st_r == H_RX) begin
                  rdv_nxt = 1'b1;
                  rdd_nxt = rx_r;
                  len_nxt = len_r - 8'h01;
                  if (len_r == 8'h01) st_nxt = H_STOP;
                end else if (!ackin_r) begin
                  nack_nxt = 1'b1;
                  st_nxt = H_STOP;
                end else begin
                  case (sq_r)
                    SQ_AW: begin
                      tx_nxt = reg_r;
                      sq_nxt = SQ_REG;
                    end
                    SQ_REG: begin
                      if (len_r == 8'h00) st_nxt = H_STOP;
                      else if (rd_r) begin
                        sq_nxt = SQ_AR;
                        st_nxt = H_START;
                      end else sq_nxt = SQ_WD;
                    end
                    SQ_WD: begin
                      len_nxt = len_r - 8'h01;
                      if (len_r == 8'h01) st_nxt = H_STOP;
                    end
                    default: begin
                      sq_nxt = SQ_RD;
                      st_nxt = H_RX;
                    end
                  endcase
                end
              end
            end
          endcase
        end
        default: begin
          case (ph_r)
            PH_SET: sda_oe_nxt = 1'b1;
            PH_RISE: scl_oe_nxt = 1'b0;
            PH_SAMPLE: sda_oe_nxt = 1'b0; // SDA rises while SCL high
            default: begin
              st_nxt = H_IDLE;
              done_nxt = 1'b1;
              rdy_nxt = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= H_IDLE; sq_r <= SQ_AW; ph_r <= PH_SET; bit_r <= 4'h0;
      tmr_r <= 16'h0000; tx_r <= 8'h00; rx_r <= 8'h00; len_r <= 8'h00;
      reg_r <= 8'h00; rd_r <= 1'b0; scl_oe_r <= 1'b0; sda_oe_r <= 1'b0;
      rdy_r <= 1'b1; rdv_r <= 1'b0; rdd_r <= 8'h00; done_r <= 1'b0;
      nack_r <= 1'b0; ackin_r <= 1'b0;
    end else begin
      st_r <= st_nxt; sq_r <= sq_nxt; ph_r <= ph_nxt; bit_r <= bit_nxt;
      tmr_r <= tmr_nxt; tx_r <= tx_nxt; rx_r <= rx_nxt; len_r <= len_nxt;
      reg_r <= reg_nxt; rd_r <= rd_nxt; scl_oe_r <= scl_oe_nxt; sda_oe_r <= sda_oe_nxt;
      rdy_r <= rdy_nxt; rdv_r <= rdv_nxt; rdd_r <= rdd_nxt; done_r <= done_nxt;
      nack_r <= nack_nxt; ackin_r <= ackin_nxt;
    end
  end

  // ==========================================================
  // Outputs; open drain, so only the enables carry information
  assign link.scl_oe_h = scl_oe_r;
  assign link.scl_out_h = 1'b0;
  assign link.sda_oe_h = sda_oe_r;
  assign link.sda_out_h = 1'b0;
  assign cmd_ready = rdy_r;
  assign rd_valid = rdv_r;
  assign rd_data = rdd_r;
  assign done = done_r;
  assign nack = nack_r;
endmodule

// ==== bench/i2c_link_sva.sv ====
// Concurrent checks on the two-wire link between host end and client end
`timescale 1ns/100ps
module i2c_link_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_c,
  input wire logic sda_oe_c,
  input wire logic sda_oe_h,
  input wire logic bus_busy
);
  logic [3:0] slot_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Bit slot tracker: 1..8 data bits, 9 ack, cleared by START
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_r <= 4'h0;
    end else if (scl && $past(scl) && $fell(sda)) begin
      slot_r <= 4'h0;
    end else if ($rose(scl)) begin
      slot_r <= (slot_r == 4'h9) ? 4'h1 : slot_r + 4'h1;
    end
  end
  // ==========================================================
  // Bus conditions; both need SCL high on two edges so a bit change is not mistaken
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  property p_no_stretch;
    !scl_oe_c;
  endproperty
  a_no_stretch: assert property (p_no_stretch) else $error("client pulled SCL");
  property p_client_low_phase;
    $changed(sda_oe_c) |-> !scl;
  endproperty
  a_client_low_phase: assert property (p_client_low_phase)
    else $error("client moved SDA while SCL high");
  // At an ack hand-over both ends may pull low for a few cycles while SCL is low;
  // harmless on a wired-AND line, so only the high portion is checked
  property p_one_talker;
    scl |-> !(sda_oe_c && sda_oe_h);
  endproperty
  a_one_talker: assert property (p_one_talker) else $error("both ends drive SDA");
  property p_ack_steady;
    (slot_r == 4'h9 && scl && $past(scl)) |-> $stable(sda);
  endproperty
  a_ack_steady: assert property (p_ack_steady) else $error("SDA moved in ack pulse");
  property p_busy_start;
    s_start |-> ##[1:6] bus_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not set by START");
  property p_free_stop;
    s_stop |-> ##[1:6] !bus_busy;
  endproperty
  a_free_stop: assert property (p_free_stop) else $error("busy not cleared by STOP");
  property p_whole_bytes;
    s_stop |-> slot_r == 4'h1;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes) else $error("STOP inside a byte");
  property p_start_host;
    s_start |-> sda_oe_h;
  endproperty
  a_start_host: assert property (p_start_host) else $error("START not made by host");
endmodule

// ==== bench/i2c_client_register_port_test.sv ====
// Self-checking bench: host and client ends joined, plus a mismatched-address pair
`timescale 1ns/100ps
module i2c_client_register_port_test;
  import i2c_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, cmd_valid_b, cmd_read, wdata_valid, wr_ready;
  logic [7:0] cmd_reg, cmd_len, wdata, rd_data, wr_addr, wr_data, r;
  logic cmd_ready, wdata_ready, rd_valid, done, nack, wr_stb, bus_busy;
  logic cmd_ready_b, done_b, nack_b, wr_stb_b;
  int err_count = 0;
  int comparisons = 0;
  int seed = 64923;
  int cycles = 0;
  int acc;
  logic [7:0] mem [256];
  logic [7:0] fifo_q [$];
  logic [7:0] exp_a [$];
  logic [7:0] exp_d [$];
  logic [7:0] exp_r [$];
  i2c_link_if link ();
  i2c_link_if link_b ();
  i2c_host #(.QTR(8)) i_i2c_host (.clk, .sys_rst, .link(link), .cmd_valid, .cmd_read,
    .cmd_reg, .cmd_len, .cmd_ready, .wdata_valid, .wdata, .wdata_ready, .rd_valid,
    .rd_data, .done, .nack);
  i2c_client i_i2c_client (.clk, .sys_rst, .link(link), .wr_ready, .wr_stb, .wr_addr,
    .wr_data, .bus_busy);
  // Second pair at a slower rate with a host aimed at a foreign address
  i2c_host #(.CLIENT_ADDR(7'h2A), .QTR(12)) i_i2c_host_b (.clk, .sys_rst, .link(link_b),
    .cmd_valid(cmd_valid_b), .cmd_read, .cmd_reg, .cmd_len, .cmd_ready(cmd_ready_b),
    .wdata_valid, .wdata, .wdata_ready(), .rd_valid(), .rd_data(), .done(done_b),
    .nack(nack_b));
  i2c_client i_i2c_client_b (.clk, .sys_rst, .link(link_b), .wr_ready, .wr_stb(wr_stb_b),
    .wr_addr(), .wr_data(), .bus_busy());
  i2c_link_sva i_i2c_link_sva (.clk, .sys_rst, .scl(link.scl), .sda(link.sda),
    .scl_oe_c(link.scl_oe_c), .sda_oe_c(link.sda_oe_c), .sda_oe_h(link.sda_oe_h), .bus_busy);
  // ==========================================================
  // Clock and hang guard; the whole run needs about 14300 cycles
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Result monitors compare every stored and every read byte with the model;
  // falling edge, so the one-cycle pulses are looked at where they have settled
  always @(negedge clk) begin
    if (wr_stb === 1'b1) begin
      chk("wr_addr", exp_a.pop_front(), wr_addr);
      chk("wr_data", exp_d.pop_front(), wr_data);
    end
    if (rd_valid === 1'b1) chk("rd_data", exp_r.pop_front(), rd_data);
    if (wr_stb_b === 1'b1) chk("wr_stb_b", 8'h00, 8'h01);
  end
  // Offer n bytes; the FIFO only takes them while it reports room
  task automatic fill(input int n);
    acc = 0;
    repeat (n) begin
      @(negedge clk);
      wdata_valid = wdata_ready;
      wdata = 8'($random(seed));
      if (wdata_ready === 1'b1) begin
        fifo_q.push_back(wdata);
        acc++;
      end
    end
    @(negedge clk);
    wdata_valid = 1'b0;
  endtask
  // Model: stored bytes land at consecutive addresses, wrapping at 8 bits
  task automatic plan(input logic rd, input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      if (rd) begin
        exp_r.push_back(mem[8'(a + i)]);
      end else begin
        exp_a.push_back(8'(a + i));
        exp_d.push_back(fifo_q[0]);
        mem[8'(a + i)] = fifo_q.pop_front();
      end
    end
  endtask
  // One command; done is a one-cycle pulse, so it is looked at on falling edges
  task automatic run(input logic rd, input logic [7:0] a, input logic [7:0] n, input logic b);
    int k;
    @(negedge clk);
    cmd_read = rd;
    cmd_reg = a;
    cmd_len = n;
    cmd_valid = !b;
    cmd_valid_b = b;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_valid_b = 1'b0;
    k = 0;
    while ((b ? done_b : done) !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k == 20000) err_count++;
    chk("cmd_ready", 8'h01, {7'h00, b ? cmd_ready_b : cmd_ready});
    chk("bus_busy", 8'h00, {7'h00, bus_busy});
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    cmd_valid = 1'b0;
    cmd_valid_b = 1'b0;
    cmd_read = 1'b0;
    cmd_reg = 8'h00;
    cmd_len = 8'h00;
    wdata_valid = 1'b0;
    wdata = 8'h00;
    wr_ready = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    // Fill until refused, then one long write that wraps FFh to 00h
    fill(10);
    chk("fifo_taken", 8'h08, 8'(acc));
    plan(1'b0, 8'hFC, 8);
    run(1'b0, 8'hFC, 8'h08, 1'b0);
    chk("nack_wr", 8'h00, {7'h00, nack});
    // Read back across the wrap, through a repeated START
    plan(1'b1, 8'hFE, 4);
    run(1'b1, 8'hFE, 8'h04, 1'b0);
    chk("rd_left", 8'h00, 8'(exp_r.size()));
    // Random single writes each followed at once by a read
    repeat (3) begin
      r = 8'($random(seed));
      fill(1);
      plan(1'b0, r, 1);
      run(1'b0, r, 8'h01, 1'b0);
      plan(1'b1, r, 1);
      run(1'b1, r, 8'h01, 1'b0);
    end
    // Client not ready: byte refused, old contents remain
    fill(1);
    void'(fifo_q.pop_front());
    wr_ready = 1'b0;
    run(1'b0, 8'h01, 8'h01, 1'b0);
    chk("nack_full", 8'h01, {7'h00, nack});
    wr_ready = 1'b1;
    plan(1'b1, 8'h01, 1);
    run(1'b1, 8'h01, 8'h01, 1'b0);
    chk("nack_clr", 8'h00, {7'h00, nack});
    // Foreign address on the second link is declined; one data byte is
    // offered so that a wrongly accepted address would show up as a store
    run(1'b0, 8'h05, 8'h01, 1'b1);
    chk("nack_b", 8'h01, {7'h00, nack_b});
    report_and_stop();
  end
endmodule
